// ==== core/tpi_pkg.sv ====
// Shared constants, register map and carrier types for the timer pin initialisation block.
// Notes on behaviour
// - Waveform outputs low, port pins undriven after reset.
// - Every channel resets into normal mode.
// - I/O control write drives pins to initial level.
// - Pulse mode one leaves B and D pins untouched.
// - Pulse mode two leaves cycle-register pin untouched.
// - Buffered C/D pins skip init in normal, mode two.
// - Pulse mode one with buffering skips C pin.
// - Pulse mode two allowed on channels 0-2 only.
// - Phase counting allowed on channels 1-2 only.
// - No transitions between those two modes and the complementary modes.
// - Counter start bit runs or halts counter.
// - Compare match drives pin to selected level.
// - Complementary modes only on channels 3 and 4.
package tpi_pkg;

  localparam int NUM_CH = 5;
  localparam int PINS_PER_CH = 4;
  localparam int NUM_PIN = NUM_CH * PINS_PER_CH;
  localparam int CNT_W_DEFAULT = 16;

  // Mode-select field codes; unlisted codes are refused.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PWM_ONE = 3'h2;
  localparam logic [2:0] MODE_PWM_TWO = 3'h3;
  localparam logic [2:0] MODE_PHASE = 3'h4;
  localparam logic [2:0] MODE_RESET_SYNC = 3'h5;
  localparam logic [2:0] MODE_COMPL = 3'h6;

  // Pin order inside a channel.
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  // One nibble per pin in the I/O control register.
  localparam int IOF_W = 4;
  localparam int IOF_EN = 3;
  localparam int IOF_INIT = 2;
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Per-channel auxiliary register fields.
  localparam int AUX_BUF_C = 0;
  localparam int AUX_BUF_D = 1;
  localparam int AUX_CYC_LSB = 2;
  localparam int AUX_CYC_MSB = 3;

  // Output control polarity fields.
  localparam int OCR_POS = 0;
  localparam int OCR_NEG = 1;

  // Only channels 3 and 4 own a master enable bit.
  localparam logic [4:0] OEN_MASK = 5'h18;

  // Address map: bits 11:8 pick the region, channel blocks are 32 bytes apart.
  localparam logic [3:0] REGION_CH = 4'h0;
  localparam logic [3:0] REGION_GLOBAL = 4'h1;
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_IOC = 3'h1;
  localparam logic [2:0] REG_AUX = 3'h2;
  localparam logic [2:0] REG_CNT = 3'h3;
  localparam logic [5:0] GREG_START = 6'h00;
  localparam logic [5:0] GREG_OEN = 6'h01;
  localparam logic [5:0] GREG_OCR = 6'h02;
  localparam logic [5:0] GREG_STATUS = 6'h03;
  localparam logic [5:0] GREG_LEVEL = 6'h04;
  localparam logic [5:0] GREG_PFC = 6'h05;
  localparam logic [5:0] GREG_PDATA = 6'h06;
  localparam logic [5:0] GREG_PDIR = 6'h07;
  localparam int STATUS_REFUSED = 0;

  typedef struct packed {
    logic [NUM_PIN-1:0] o;
    logic [NUM_PIN-1:0] oe;
  } tpi_pin_t;

endpackage

// ==== core/tpi_timer_pins.sv ====
// Multi-channel timer output pins with initialisation, mode guard and port fallback.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tpi_timer_pins
  import tpi_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tpi_pin_t pins,
  output logic [NUM_CH-1:0] counting
);

  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie between 2 and 32");
    end
  endgenerate

  typedef struct packed {
    logic [NUM_CH-1:0][2:0] mode;
    logic [NUM_CH-1:0][15:0] ioc;
    logic [NUM_CH-1:0][3:0] aux;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt;
    logic [NUM_CH-1:0][3:0][CNT_W-1:0] gen;
    logic [NUM_CH-1:0] start;
    logic [NUM_CH-1:0] oen;
    logic [1:0] ocr;
    logic refused;
    logic [NUM_PIN-1:0] level;
    logic [NUM_PIN-1:0] pin_function_controller;
    logic [NUM_PIN-1:0] pdata;
    logic [NUM_PIN-1:0] pdir;
    logic [31:0] rdata;
    logic err;
  } tpi_state_t;

  tpi_state_t state_reg;
  tpi_state_t state_next;

  function automatic logic mode_legal(input int ch, input logic [2:0] m);
    logic ok;
    ok = 1'b0;
    case (m)
      MODE_NORMAL: ok = 1'b1;
      MODE_PWM_ONE: ok = 1'b1;
      MODE_PWM_TWO: ok = (ch <= 2);
      MODE_PHASE: ok = (ch == 1) || (ch == 2);
      MODE_RESET_SYNC: ok = (ch == 3) || (ch == 4);
      MODE_COMPL: ok = (ch == 3) || (ch == 4);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_compl_group(input logic [2:0] m);
    return (m == MODE_COMPL) || (m == MODE_RESET_SYNC);
  endfunction

  function automatic logic is_counting_group(input logic [2:0] m);
    return (m == MODE_PWM_TWO) || (m == MODE_PHASE);
  endfunction

  // A direct hop between the two groups is refused in both directions.
  function automatic logic transition_ok(input logic [2:0] from, input logic [2:0] to);
    return !((is_counting_group(from) && is_compl_group(to)) ||
             (is_compl_group(from) && is_counting_group(to)));
  endfunction

  // Pins that carry no waveform in the current mode: they neither initialise nor
  // follow compare matches, so both paths share this one decision.
  function automatic logic pin_silent(input logic [2:0] m, input logic [3:0] ax, input int p);
    logic bc;
    logic bd;
    logic s;
    bc = ax[AUX_BUF_C];
    bd = ax[AUX_BUF_D];
    s = 1'b1;
    case (m)
      MODE_NORMAL: s = (p == PIN_C && bc) || (p == PIN_D && bd);
      MODE_PWM_ONE: s = (p == PIN_B) || (p == PIN_D) ||
                        (p == PIN_C && (bc || bd));
      MODE_PWM_TWO: s = (p == int'(ax[AUX_CYC_MSB:AUX_CYC_LSB])) ||
                        (p == PIN_C && bc) || (p == PIN_D && bd);
      MODE_PHASE: s = 1'b0;
      default: s = 1'b1;
    endcase
    return s;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'h0) begin
      if (a[11:8] == REGION_CH) begin
        ok = (a[7:5] < 3'(NUM_CH));
      end else if (a[11:8] == REGION_GLOBAL) begin
        ok = (a[7:2] <= GREG_PDIR);
      end
    end
    return ok;
  endfunction

  function automatic logic [31:0] read_word(input tpi_state_t st, input logic [11:0] a);
    logic [31:0] d;
    int c;
    d = '0;
    c = int'(a[7:5]);
    if (addr_mapped(a) && a[11:8] == REGION_CH) begin
      if (a[4]) begin
        d[CNT_W-1:0] = st.gen[c][a[3:2]];
      end else begin
        case (a[4:2])
          REG_MODE: d[2:0] = st.mode[c];
          REG_IOC: d[15:0] = st.ioc[c];
          REG_AUX: d[3:0] = st.aux[c];
          default: d[CNT_W-1:0] = st.cnt[c];
        endcase
      end
    end else if (addr_mapped(a)) begin
      case (a[7:2])
        GREG_START: d[NUM_CH-1:0] = st.start;
        GREG_OEN: d[NUM_CH-1:0] = st.oen;
        GREG_OCR: d[1:0] = st.ocr;
        GREG_STATUS: d[STATUS_REFUSED] = st.refused;
        GREG_LEVEL: d[NUM_PIN-1:0] = st.level;
        GREG_PFC: d[NUM_PIN-1:0] = st.pin_function_controller;
        GREG_PDATA: d[NUM_PIN-1:0] = st.pdata;
        default: d[NUM_PIN-1:0] = st.pdir;
      endcase
    end
    return d;
  endfunction

  // Channels 0 to 2 have no master enable and always may drive.
  function automatic logic out_allowed(input tpi_state_t st, input int ch);
    return (ch < 3) || st.oen[ch];
  endfunction

  always_comb begin
    int idx;
    int wch;
    logic [IOF_W-1:0] fld;
    logic [2:0] new_mode;
    idx = 0;
    fld = '0;
    wch = int'(paddr[7:5]);
    new_mode = pwdata[2:0];
    state_next = state_reg;
    if (ce) begin
      // Read data and error are captured in the setup phase so both come from flops.
      if (psel && !penable) begin
        state_next.rdata = read_word(state_reg, paddr);
        state_next.err = !addr_mapped(paddr);
      end

      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (state_reg.start[ch]) begin
          state_next.cnt[ch] = state_reg.cnt[ch] + CNT_W'(1);
        end
        if (!is_compl_group(state_reg.mode[ch]) && state_reg.start[ch]) begin
          for (int p = 0; p < PINS_PER_CH; p++) begin
            idx = ch * PINS_PER_CH + p;
            fld = state_reg.ioc[ch][p*IOF_W +: IOF_W];
            if (fld[IOF_EN] && !pin_silent(state_reg.mode[ch], state_reg.aux[ch], p) &&
                state_reg.cnt[ch] == state_reg.gen[ch][p]) begin
              case (fld[1:0])
                ACT_LOW: state_next.level[idx] = 1'b0;
                ACT_HIGH: state_next.level[idx] = 1'b1;
                ACT_TOGGLE: state_next.level[idx] = !state_reg.level[idx];
                default: state_next.level[idx] = state_reg.level[idx];
              endcase
            end
          end
        end
      end

      // Writes land at the access edge; an initialisation therefore overrides a
      // compare match in the same cycle and shows on the pin right after that same edge.
      if (psel && penable && pwrite && !state_reg.err) begin
        if (paddr[11:8] == REGION_CH) begin
          if (paddr[4]) begin
            state_next.gen[wch][paddr[3:2]] = pwdata[CNT_W-1:0];
          end else begin
            unique case (paddr[4:2])
              REG_MODE: begin
                if (mode_legal(wch, new_mode) &&
                    transition_ok(state_reg.mode[wch], new_mode)) begin
                  state_next.mode[wch] = new_mode;
                end else begin
                  state_next.refused = 1'b1;
                end
              end
              REG_IOC: begin
                state_next.ioc[wch] = pwdata[15:0];
                for (int p = 0; p < PINS_PER_CH; p++) begin
                  idx = wch * PINS_PER_CH + p;
                  fld = pwdata[p*IOF_W +: IOF_W];
                  if (fld[IOF_EN] && out_allowed(state_reg, wch) &&
                      !pin_silent(state_reg.mode[wch], state_reg.aux[wch], p)) begin
                    state_next.level[idx] = fld[IOF_INIT];
                  end
                end
              end
              REG_AUX: state_next.aux[wch] = pwdata[3:0];
              REG_CNT: state_next.cnt[wch] = pwdata[CNT_W-1:0];
              default: state_next.aux[wch] = state_reg.aux[wch];
            endcase
          end
        end else begin
          unique case (paddr[7:2])
            GREG_START: state_next.start = pwdata[NUM_CH-1:0];
            GREG_OEN: state_next.oen = pwdata[NUM_CH-1:0] & OEN_MASK;
            GREG_OCR: state_next.ocr = pwdata[1:0];
            GREG_STATUS: begin
              if (pwdata[STATUS_REFUSED]) begin
                state_next.refused = 1'b0;
              end
            end
            GREG_LEVEL: begin
              // Pin levels are read-only; a write must not undo a compare match.
            end
            GREG_PFC: state_next.pin_function_controller = pwdata[NUM_PIN-1:0];
            GREG_PDATA: state_next.pdata = pwdata[NUM_PIN-1:0];
            GREG_PDIR: state_next.pdir = pwdata[NUM_PIN-1:0];
            default: state_next.pin_function_controller = state_reg.pin_function_controller;
          endcase
        end
      end

      // Complementary levels follow the polarity fields from the same edge as the
      // mode or output control write, so the pins never lag a cycle without cause.
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (is_compl_group(state_next.mode[ch])) begin
          for (int p = 0; p < PINS_PER_CH; p++) begin
            idx = ch * PINS_PER_CH + p;
            state_next.level[idx] = (p == PIN_A || p == PIN_C) ?
                                    state_next.ocr[OCR_POS] : state_next.ocr[OCR_NEG];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pin routing: each pin shows either the timer or the plain port, so software can
  // cut a faulty waveform by flipping the routing bit without stopping the counter.
  always_comb begin
    int idx;
    logic ten;
    idx = 0;
    ten = 1'b0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      for (int p = 0; p < PINS_PER_CH; p++) begin
        idx = ch * PINS_PER_CH + p;
        if (is_compl_group(state_reg.mode[ch])) begin
          ten = state_reg.oen[ch];
        end else begin
          ten = state_reg.ioc[ch][p*IOF_W + IOF_EN] && out_allowed(state_reg, ch);
        end
        pins.o[idx] = state_reg.pin_function_controller[idx] ? state_reg.level[idx] : state_reg.pdata[idx];
        pins.oe[idx] = state_reg.pin_function_controller[idx] ? ten : state_reg.pdir[idx];
      end
    end
  end

  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.err && psel && penable;
  assign pready = ce;
  assign counting = state_reg.start;

endmodule
`default_nettype wire

// ==== test/tpi_timer_pins_checker.sv ====
// Port-level timing checks for the timer pin block.
`timescale 1ns/100ps
`default_nettype none
module tpi_timer_pins_checker
  import tpi_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tpi_pin_t pins,
  input wire logic [NUM_CH-1:0] counting
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_acc = psel && penable && pwrite && pready;
  wire logic [4:0] start_w = pwdata[4:0];
  wire logic ioc_off = paddr[11:8] == 4'h0 && paddr[4:0] == 5'h04;
  reset_pins_low_a: assert property ($rose(presetn) |-> pins.o == '0 && pins.oe == '0)
    else $error("pins not idle after reset");
  pins_hold_idle_a: assert property (!wr_acc && counting == '0 |=> $stable(pins.o))
    else $error("pin level moved without a cause");
  oe_hold_a: assert property (!wr_acc |=> $stable(pins.oe))
    else $error("pin enable moved without a write");
  start_write_a: assert property (wr_acc && paddr == 12'h100 |=> counting == $past(start_w))
    else $error("counting does not follow start write");
  count_hold_a: assert property (!wr_acc |=> $stable(counting))
    else $error("counting moved without a write");
  ce_freeze_a: assert property (!ce |=> $stable(pins.o) && $stable(counting))
    else $error("state moved while clock enable low");
  ioc_noinit_a: assert property (wr_acc && ioc_off && (pwdata[15:0] & 16'h8888) == 16'h0000
    && counting == '0 |=> $stable(pins.o))
    else $error("disabled field changed a pin");
  ready_ce_a: assert property (pready == ce)
    else $error("ready does not follow clock enable");
  cover property (wr_acc && paddr == 12'h100 && pwdata[0]);
  cover property (pslverr);
  cover property ($rose(pins.o[0]) && counting[0]);
endmodule
bind tpi_timer_pins tpi_timer_pins_checker #(.CNT_W(CNT_W)) u_tpi_timer_pins_checker (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .pins, .counting);
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the timer pin block.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tpi_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, pslverr, pready, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1;
  logic [31:0] seed = 32'hba2b;
  tpi_pin_t pins;
  logic [NUM_CH-1:0] counting;
  logic [19:0] lv = '0;
  int miscompares = 0;
  int n_tests = 0;
  tpi_timer_pins #(.CNT_W(8)) u_tpi_timer_pins (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .counting(counting));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] init_lv(input logic [2:0] m, input logic [15:0] io,
      input logic [3:0] ax, input logic [3:0] old);
    logic [3:0] r;
    logic sil;
    r = old;
    for (int p = 0; p < 4; p++) begin
      sil = (m == MODE_PWM_ONE && (p == PIN_B || p == PIN_D))
        || (m == MODE_PWM_ONE && p == PIN_C && ax[1:0] != 2'h0)
        || ((m == MODE_NORMAL || m == MODE_PWM_TWO)
        && ((p == PIN_C && ax[AUX_BUF_C]) || (p == PIN_D && ax[AUX_BUF_D])))
        || (m == MODE_PWM_TWO && p == int'(ax[3:2]));
      if (io[p*4+IOF_EN] && !sil) r[p] = io[p*4+IOF_INIT];
    end
    return r;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pin_chk();
    apb(1'b0, 12'h110, '0);
    chk(rd, 32'(lv));
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    for (int c = 1; c <= 20000; c++) @(posedge pclk);
    miscompares++;
    close_out();
  end
  initial begin
    logic [2:0] m;
    logic [3:0] ax;
    logic [15:0] io;
    int ch;
    int rch[5] = '{0, 3, 4, 1, 2};
    logic [2:0] rm[5] = '{MODE_PHASE, MODE_PWM_TWO, MODE_PHASE, MODE_COMPL, MODE_RESET_SYNC};
    logic [2:0] tbl[4] = '{MODE_NORMAL, MODE_PWM_ONE, MODE_PWM_TWO, MODE_PHASE};
    {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(32'(pins.oe), '0);
    chk(32'(pins.o), '0);
    chk(32'(counting), '0);
    for (int c = 0; c < NUM_CH; c++) begin
      apb(1'b0, 12'(c * 32), '0);
      chk(rd, MODE_NORMAL);
    end
    apb(1'b1, 12'h104, 32'h18);
    repeat (40) begin
      ch = int'(rnd() % 5);
      m = tbl[rnd() % 4];
      if (ch > 2 && m > MODE_PWM_ONE) m = MODE_PWM_ONE;
      if (ch == 0 && m == MODE_PHASE) m = MODE_PWM_TWO;
      ax = rnd();
      io = rnd();
      apb(1'b1, 12'(ch * 32), 32'(m));
      apb(1'b1, 12'(ch * 32 + 8), 32'(ax));
      apb(1'b1, 12'(ch * 32 + 4), 32'(io));
      lv[ch*4+:4] = init_lv(m, io, ax, lv[ch*4+:4]);
      pin_chk();
    end
    // Channel 3 without its master enable must ignore the init write.
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h60, 32'(MODE_NORMAL));
    apb(1'b1, 12'h68, 32'h0);
    apb(1'b1, 12'h64, 32'hcccc);
    pin_chk();
    apb(1'b1, 12'h104, 32'h18);
    apb(1'b1, 12'h64, 32'hcccc);
    lv[12+:4] = 4'hf;
    pin_chk();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'(rch[i] * 32), 32'(MODE_NORMAL));
      apb(1'b1, 12'(rch[i] * 32), 32'(rm[i]));
      apb(1'b0, 12'(rch[i] * 32), '0);
      chk(rd, MODE_NORMAL);
      apb(1'b0, 12'h10c, '0);
      chk(rd[STATUS_REFUSED], 1'b1);
      apb(1'b1, 12'h10c, 32'h1);
    end
    apb(1'b1, 12'h64, 32'h0);
    apb(1'b1, 12'h104, 32'h0);
    apb(1'b1, 12'h108, 32'h1);
    apb(1'b1, 12'h60, 32'(MODE_COMPL));
    apb(1'b1, 12'h104, 32'h18);
    lv[12+:4] = 4'b0101;
    pin_chk();
    apb(1'b1, 12'h64, 32'hcccc);
    pin_chk();
    apb(1'b1, 12'h60, 32'(MODE_PWM_TWO));
    apb(1'b0, 12'h60, '0);
    chk(rd, MODE_COMPL);
    apb(1'b1, 12'h60, 32'(MODE_NORMAL));
    apb(1'b1, 12'h08, 32'h0);
    apb(1'b1, 12'h00, 32'(MODE_NORMAL));
    apb(1'b1, 12'h10, 32'h5);
    apb(1'b1, 12'h0c, 32'h0);
    apb(1'b1, 12'h04, 32'h000a);
    lv[0] = 1'b0;
    pin_chk();
    chk(pins.oe[0], 1'b0);
    apb(1'b1, 12'h114, 32'h1);
    @(negedge pclk);
    chk(pins.oe[0], 1'b1);
    apb(1'b1, 12'h100, 32'h1);
    @(negedge pclk);
    chk(counting, 5'h01);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    for (int i = 0; i < 40 && pins.o[0] !== 1'b1; i++) @(posedge pclk);
    lv[0] = 1'b1;
    chk(32'(pins.o[0]), 32'h1);
    pin_chk();
    apb(1'b1, 12'h118, 32'h1);
    apb(1'b1, 12'h11c, 32'h1);
    apb(1'b1, 12'h114, 32'h0);
    @(negedge pclk);
    chk(32'(pins.o[0]), 32'h1);
    chk(32'(pins.oe[0]), 32'h1);
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b0, 12'h0c, '0);
    r1 = rd;
    repeat (5) @(posedge pclk);
    apb(1'b0, 12'h0c, '0);
    chk(rd, r1);
    chk(counting, 5'h00);
    apb(1'b1, 12'h04, 32'h000c);
    lv[0] = 1'b1;
    pin_chk();
    apb(1'b1, 12'h114, 32'h1);
    apb(1'b1, 12'h100, 32'h1);
    @(negedge pclk);
    chk(counting, 5'h01);
    apb(1'b0, 12'h1f0, '0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
